/* File: verilog/dse_map.svh */
`ifndef DSE_MAP_SVH
`define DSE_MAP_SVH
// Register offsets (byte addresses on the target port)
`define DSE_OFS_CONTROL 8'h04
`define DSE_OFS_STATUS 8'h08
`define DSE_OFS_FAULT_ADDR 8'h0C
`define DSE_OFS_Q1_ADDR 8'h00
`define DSE_OFS_Q2_ADDR 8'h10
// Status field positions
`define DSE_BIT_BUSY 31
`define DSE_BIT_Q1_FULL 30
`define DSE_BIT_Q1_DONE 29
`define DSE_BIT_FAULT 28
`define DSE_BIT_Q2_FULL 27
`define DSE_BIT_Q2_DONE 26
// Control field positions
`define DSE_BIT_SOFT_RESET 31
`define DSE_BIT_FAULT_EN 25
`define DSE_BIT_Q1_EN 30
`define DSE_BIT_Q2_EN 29
// Fault address fields
`define DSE_BIT_FAULT_READ 1
`define DSE_RST_CONTROL 32'h00000000
`endif

/* File: verilog/dse_pkg.sv */
package dse_pkg;
	typedef logic [31:0] dse_word_t;
	typedef logic [7:0] dse_addr_t;
endpackage

/* File: verilog/dse_regs.sv */
`timescale 1ns/1ps
`include "dse_map.svh"
// Notes on behaviour
// - Status bit 31 shows master access busy
// - Bit 30 set while both queue one slots are full
// - Bit 29 sticky done, cleared writing one
// - Done status recorded even when disabled
// - Interrupt only with matching enable set
// - Bit 28 set on master access error
// - Fault sticky until reset or soft reset
// - Fault recorded even with enable off
// - Bit 27 set while both queue two slots are full
// - Bit 26 sticky done, cleared writing one
// - Fault word address captured in 31:2
// - Control bit 25 enables fault interrupt
// - Queue address registers are double buffered
// - Bit 1 records read or write fault
module dse_regs (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Register access from the target port
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire dse_pkg::dse_addr_t reg_addr,
	input wire dse_pkg::dse_word_t reg_wdata,
	output dse_pkg::dse_word_t reg_rdata,
	// Engine side: record fetch from each queue
	output logic q1_req_valid,
	output dse_pkg::dse_word_t q1_req_addr,
	input wire logic q1_req_take,
	output logic q2_req_valid,
	output dse_pkg::dse_word_t q2_req_addr,
	input wire logic q2_req_take,
	// Engine events
	input wire logic master_busy,
	input wire logic q1_done,
	input wire logic q2_done,
	input wire logic fault_evt,
	input wire dse_pkg::dse_word_t fault_addr,
	input wire logic fault_is_read,
	// Interrupt and soft reset
	output logic irq,
	output logic soft_reset
);
	import dse_pkg::*;

	logic [31:0] ctrl_q;
	logic busy_q, q1_done_q, q2_done_q, fault_q;
	logic [29:0] fault_word_q;
	logic fault_rd_q;
	logic head_full_q [2];
	logic tail_full_q [2];
	dse_word_t head_q [2];
	dse_word_t tail_q [2];
	logic [1:0] push;
	logic [1:0] take;
	logic [1:0] done_clr;
	logic soft_pulse;

	// Decode of the strobes
	assign push[0] = reg_wr && reg_addr == `DSE_OFS_Q1_ADDR;
	assign push[1] = reg_wr && reg_addr == `DSE_OFS_Q2_ADDR;
	assign take[0] = q1_req_take;
	assign take[1] = q2_req_take;
	assign soft_pulse = reg_wr && reg_addr == `DSE_OFS_CONTROL && reg_wdata[`DSE_BIT_SOFT_RESET];
	assign done_clr[0] = reg_wr && reg_addr == `DSE_OFS_STATUS && reg_wdata[`DSE_BIT_Q1_DONE];
	assign done_clr[1] = reg_wr && reg_addr == `DSE_OFS_STATUS && reg_wdata[`DSE_BIT_Q2_DONE];

	// Control register; the soft reset bit self-clears so it acts once
	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl_q <= `DSE_RST_CONTROL;
		end else if (reg_wr && reg_addr == `DSE_OFS_CONTROL) begin
			ctrl_q <= reg_wdata & ~(32'h80000000);
		end
	end
	assign soft_reset = soft_pulse;

	// Two-entry queue per record register: head feeds engine, tail holds the next
	// A push with both slots taken and no take in that cycle is dropped; software polls the full flag first
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_queue
			always_ff @(posedge core_clk) begin
				if (rst || soft_pulse) begin
					head_full_q[g] <= 1'b0;
					tail_full_q[g] <= 1'b0;
				end else begin
					// Tail moves up when head drains; a push lands in the first free slot
					if (take[g] && head_full_q[g]) begin
						head_full_q[g] <= tail_full_q[g] || push[g];
						tail_full_q[g] <= tail_full_q[g] && push[g];
						head_q[g] <= tail_full_q[g] ? tail_q[g] : reg_wdata;
						if (tail_full_q[g] && push[g]) begin
							tail_q[g] <= reg_wdata;
						end
					end else if (push[g] && !head_full_q[g]) begin
						head_full_q[g] <= 1'b1;
						head_q[g] <= reg_wdata;
					end else if (push[g] && !tail_full_q[g]) begin
						tail_full_q[g] <= 1'b1;
						tail_q[g] <= reg_wdata;
					end
				end
			end
		end
	endgenerate
	assign q1_req_valid = head_full_q[0];
	assign q1_req_addr = head_q[0];
	assign q2_req_valid = head_full_q[1];
	assign q2_req_addr = head_q[1];

	// Busy flag follows the engine, registered for the status read
	always_ff @(posedge core_clk) begin
		if (rst) begin
			busy_q <= 1'b0;
		end else begin
			busy_q <= master_busy;
		end
	end

	// Sticky done flags: a new completion wins over a write-one clear
	always_ff @(posedge core_clk) begin
		if (rst) begin
			q1_done_q <= 1'b0;
			q2_done_q <= 1'b0;
		end else begin
			q1_done_q <= q1_done || (q1_done_q && !done_clr[0]);
			q2_done_q <= q2_done || (q2_done_q && !done_clr[1]);
		end
	end

	// Fault status ends only by reset or soft reset; new fault during soft reset still sticks
	always_ff @(posedge core_clk) begin
		if (rst) begin
			fault_q <= 1'b0;
		end else begin
			fault_q <= fault_evt || (fault_q && !soft_pulse);
		end
	end

	// Fault address capture; no reset since its value is undefined until a fault
	always_ff @(posedge core_clk) begin
		if (fault_evt) begin
			fault_word_q <= fault_addr[31:2];
			fault_rd_q <= fault_is_read;
		end
	end

	// Interrupt request: each done and fault status gated by its own enable
	always_ff @(posedge core_clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= (q1_done_q && ctrl_q[`DSE_BIT_Q1_EN]) || (q2_done_q && ctrl_q[`DSE_BIT_Q2_EN])
				|| (fault_q && ctrl_q[`DSE_BIT_FAULT_EN]);
		end
	end

	// Read data, registered one cycle after the read strobe
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				`DSE_OFS_CONTROL: reg_rdata <= ctrl_q;
				`DSE_OFS_STATUS: begin
					reg_rdata <= 32'h00000000;
					reg_rdata[`DSE_BIT_BUSY] <= busy_q;
					reg_rdata[`DSE_BIT_Q1_FULL] <= tail_full_q[0];
					reg_rdata[`DSE_BIT_Q1_DONE] <= q1_done_q;
					reg_rdata[`DSE_BIT_FAULT] <= fault_q;
					reg_rdata[`DSE_BIT_Q2_FULL] <= tail_full_q[1];
					reg_rdata[`DSE_BIT_Q2_DONE] <= q2_done_q;
				end
				`DSE_OFS_FAULT_ADDR: reg_rdata <= {fault_word_q, fault_rd_q, 1'b0};
				default: reg_rdata <= 32'h00000000;
			endcase
		end
	end

	// Checks beside the logic
	a_done_sticky: assert property (@(posedge core_clk) disable iff (rst)
		q1_done_q && !done_clr[0] |=> q1_done_q) else $error("queue one done lost");
	a_done_set: assert property (@(posedge core_clk) disable iff (rst)
		q2_done |=> q2_done_q) else $error("queue two done not set");
	a_fault_hold: assert property (@(posedge core_clk) disable iff (rst)
		fault_q && !soft_pulse |=> fault_q) else $error("fault dropped");
	a_fault_set: assert property (@(posedge core_clk) disable iff (rst)
		fault_evt |=> fault_q ##0 fault_word_q == $past(fault_addr[31:2])) else $error("fault not captured");
	a_irq_gate: assert property (@(posedge core_clk) disable iff (rst)
		!ctrl_q[`DSE_BIT_FAULT_EN] && !ctrl_q[`DSE_BIT_Q1_EN] && !ctrl_q[`DSE_BIT_Q2_EN]
		&& $past(ctrl_q) == ctrl_q |-> !irq) else $error("irq without enable");
	a_irq_fault: assert property (@(posedge core_clk) disable iff (rst)
		fault_q && ctrl_q[`DSE_BIT_FAULT_EN] |=> irq) else $error("fault irq missing");
	a_queue_head: assert property (@(posedge core_clk) disable iff (rst || soft_pulse)
		push[0] && !head_full_q[0] |=> q1_req_valid) else $error("queue push lost");
	a_busy_follow: assert property (@(posedge core_clk) disable iff (rst)
		master_busy |=> busy_q) else $error("busy not shown");
	a_rd_flag: assert property (@(posedge core_clk) disable iff (rst)
		fault_evt |=> fault_rd_q == $past(fault_is_read)) else $error("direction wrong");
	a_fault_clear: assert property (@(posedge core_clk) disable iff (rst)
		soft_pulse && !fault_evt |=> !fault_q) else $error("fault kept after soft reset");
	a_irq_drop: assert property (@(posedge core_clk) disable iff (rst)
		!q1_done_q && !q2_done_q && !fault_q |=> !irq) else $error("irq without status");
	a_queue_two: assert property (@(posedge core_clk) disable iff (rst || soft_pulse)
		push[1] && !head_full_q[1] |=> q2_req_valid) else $error("queue two push lost");
	a_busy_clear: assert property (@(posedge core_clk) disable iff (rst)
		!master_busy |=> !busy_q) else $error("busy stuck");
	// Reset values show at the edge after any reset cycle, mid-run ones too
	a_reset_vals: assert property (@(posedge core_clk)
		rst |=> !irq && !busy_q && !fault_q && !q1_req_valid && !q2_req_valid && reg_rdata == 32'h00000000)
		else $error("reset value wrong");
	// Main scenarios
	c_two_queued: cover property (@(posedge core_clk) tail_full_q[0]);
	c_q2_irq: cover property (@(posedge core_clk) q2_done_q && irq);
	c_fault_irq: cover property (@(posedge core_clk) fault_q && irq);
	c_clear_race: cover property (@(posedge core_clk) q1_done && done_clr[0]);
endmodule // dse_regs

/* File: tb/dse_engine.sv */
`timescale 1ns/1ps
// Record engine stand-in: fetches one head at a time while run is high
module dse_engine (
	// Clock, reset, bench control
	input wire logic core_clk,
	input wire logic rst,
	input wire logic run,
	input wire logic hold,
	// Queue handshake
	input wire logic q1_req_valid,
	input wire logic q2_req_valid,
	output logic q1_req_take,
	output logic q2_req_take,
	// Events
	output logic master_busy,
	output logic q1_done,
	output logic q2_done
);
	logic [1:0] act_q;
	// Done follows take by one cycle; hold forces master_busy high without stalling fetches
	assign master_busy = (act_q != 2'h0) | hold;
	always_ff @(posedge core_clk) begin
		q1_req_take <= 1'b0;
		q2_req_take <= 1'b0;
		q1_done <= act_q == 2'h1;
		q2_done <= act_q == 2'h2;
		act_q <= 2'h0;
		if (!rst && act_q == 2'h0 && run && q1_req_valid) begin
			q1_req_take <= 1'b1;
			act_q <= 2'h1;
		end else if (!rst && act_q == 2'h0 && run && q2_req_valid) begin
			q2_req_take <= 1'b1;
			act_q <= 2'h2;
		end
	end
endmodule // dse_engine

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`include "dse_map.svh"
module testbench;
	import dse_pkg::*;
	logic core_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, run = 0, hold = 0, fault_evt = 0, fault_is_read = 0;
	logic q1v, q2v, q1t, q2t, busy, q1d, q2d, irq, soft_rst;
	dse_addr_t reg_addr = 8'h00;
	dse_word_t reg_wdata = 32'h00000000, fault_addr = 32'h00000000, reg_rdata, q1a, q2a, a, b, fa;
	logic [31:0] st = 32'd20677;
	int errors = 0, checked = 0, cycles = 0, soft_seen = 0;
	always #4 core_clk = ~core_clk;
	dse_regs dut (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .q1_req_valid(q1v), .q1_req_addr(q1a), .q1_req_take(q1t),
		.q2_req_valid(q2v), .q2_req_addr(q2a), .q2_req_take(q2t), .master_busy(busy), .q1_done(q1d), .q2_done(q2d),
		.fault_evt(fault_evt), .fault_addr(fault_addr), .fault_is_read(fault_is_read), .irq(irq),
		.soft_reset(soft_rst));
	dse_engine eng (.core_clk(core_clk), .rst(rst), .run(run), .hold(hold), .q1_req_valid(q1v),
		.q2_req_valid(q2v), .q1_req_take(q1t), .q2_req_take(q2t), .master_busy(busy), .q1_done(q1d), .q2_done(q2d));
	function logic [31:0] rnd();
		st ^= st << 13;
		st ^= st >> 17;
		st ^= st << 5;
		return st;
	endfunction
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// Strobes are one cycle wide, and every access leaves four idle cycles before the next
	task acc(input logic w, input dse_addr_t ad, input dse_word_t d);
		@(posedge core_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask
	task conclude();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			conclude();
		end
	end
	// Soft reset pulses, seen while the control write strobe stands
	always @(posedge core_clk) begin
		if (soft_rst === 1'b1)
			soft_seen++;
	end
	initial begin
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		acc(0, `DSE_OFS_STATUS, 0); chk("status_rst", reg_rdata, 32'h00000000);
		acc(0, 8'h20, 0); chk("unmapped", reg_rdata, 32'h00000000);
		$display("test reset done");
		a = rnd();
		acc(1, `DSE_OFS_Q1_ADDR, a);
		acc(0, `DSE_OFS_STATUS, 0); chk("status_one", reg_rdata, 32'h00000000);
		acc(1, `DSE_OFS_Q1_ADDR, rnd());
		chk("q1_head", q1a, a);
		b = rnd();
		acc(1, `DSE_OFS_Q2_ADDR, b);
		acc(1, `DSE_OFS_Q2_ADDR, rnd());
		chk("q2_head", q2a, b);
		hold <= 1'b1;
		acc(0, `DSE_OFS_STATUS, 0); chk("status_full", reg_rdata, 32'hC8000000);
		hold <= 1'b0;
		run <= 1'b1;
		repeat (30) @(posedge core_clk);
		run <= 1'b0;
		acc(0, `DSE_OFS_STATUS, 0); chk("status_done", reg_rdata, 32'h24000000);
		chk("irq_off", irq, 0);
		acc(1, `DSE_OFS_CONTROL, 32'h40000000); chk("irq_on", irq, 1);
		acc(1, `DSE_OFS_STATUS, 32'h20000000); chk("irq_clr", irq, 0);
		acc(0, `DSE_OFS_STATUS, 0); chk("status_w1c", reg_rdata, 32'h04000000);
		acc(1, `DSE_OFS_CONTROL, 32'h20000000); chk("irq_q2_on", irq, 1);
		acc(1, `DSE_OFS_STATUS, 32'h04000000); chk("irq_q2_clr", irq, 0);
		$display("test queues done");
		repeat (2) begin
			fa = rnd();
			@(posedge core_clk);
			fault_evt <= 1'b1;
			fault_addr <= fa;
			fault_is_read <= fa[7];
			@(posedge core_clk);
			fault_evt <= 1'b0;
			acc(0, `DSE_OFS_STATUS, 0); chk("fault_set", reg_rdata & 32'h10000000, 32'h10000000);
			chk("fault_irq_off", irq, 0);
			acc(0, `DSE_OFS_FAULT_ADDR, 0); chk("fault_addr", reg_rdata & 32'hFFFFFFFE, {fa[31:2], fa[7], 1'b0});
			acc(1, `DSE_OFS_STATUS, 32'h10000000);
			acc(1, `DSE_OFS_CONTROL, 32'h02000000); chk("fault_irq", irq, 1);
			acc(0, `DSE_OFS_CONTROL, 0); chk("ctrl_rd", reg_rdata, 32'h02000000);
			acc(1, `DSE_OFS_CONTROL, 32'h80000000);
			acc(0, `DSE_OFS_STATUS, 0); chk("soft_rst", reg_rdata & 32'h10000000, 32'h00000000);
		end
		$display("test fault done");
		@(posedge core_clk);
		fault_evt <= 1'b1;
		@(posedge core_clk);
		fault_evt <= 1'b0;
		acc(1, `DSE_OFS_Q1_ADDR, rnd());
		acc(1, `DSE_OFS_Q1_ADDR, rnd());
		acc(1, `DSE_OFS_CONTROL, 32'h62000000); chk("fault_irq2", irq, 1);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		chk("irq_hw_rst", irq, 0);
		acc(0, `DSE_OFS_STATUS, 0); chk("status_hw_rst", reg_rdata, 32'h00000000);
		acc(0, `DSE_OFS_CONTROL, 0); chk("ctrl_hw_rst", reg_rdata, 32'h00000000);
		chk("soft_pulses", soft_seen, 2);
		$display("test hw reset done");
		conclude();
	end
endmodule // testbench
